// ### sesc_pkg.sv
// Purpose : Shared constants and types for the two-wire EEPROM slave and its bus master
// Assumes : 100 MHz system clock, link clock made by the master end
// Notes   : Long write-cycle counts are overridable parameters of the device end

// ****************************************************************
// Package
// ****************************************************************
package sesc_pkg;
	// Timing base
	localparam int CLK_PERIOD_NS  = 10;
	localparam int LINK_PERIOD_NS = 160;
	localparam int QTR_CYCLES     = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int T_WR_MS        = 4;
	localparam int T_CFG_MS       = 5;
	localparam int WR_CYCLES      = T_WR_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CFG_CYCLES     = T_CFG_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BUSY_W         = 20;

	// Memory organisation
	localparam int ADDR_W    = 13;
	localparam int PAGE_OFS_W = 5;
	localparam int MEM_BYTES = 8192;

	// Device address byte
	localparam logic [3:0] TYPE_MEM = 4'hA;
	localparam logic [3:0] TYPE_CFG = 4'hB;

	// Configuration byte layout and selection
	localparam int         CFG_AS_MSB  = 7;
	localparam int         CFG_AS_LSB  = 5;
	localparam int         CFG_WP_BIT  = 1;
	localparam logic [1:0] CFG_SEL_VAL = 2'h3;
	localparam logic [2:0] AS_RESET    = 3'h0;
	localparam logic       WP_RESET    = 1'b0;

	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_DEV  = 3'b001,
		D_AHI  = 3'b010,
		D_ALO  = 3'b011,
		D_WR   = 3'b100,
		D_RD   = 3'b101,
		D_IGN  = 3'b110,
		D_BUSY = 3'b111
	} sesc_dev_st_e;

	typedef enum logic [2:0] {
		CMD_START     = 3'b000,
		CMD_STOP      = 3'b001,
		CMD_WRITE     = 3'b010,
		CMD_READ_ACK  = 3'b011,
		CMD_READ_NACK = 3'b100,
		CMD_RECOVER   = 3'b101
	} sesc_cmd_e;

	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_START = 3'b001,
		H_STOP  = 3'b010,
		H_BYTE  = 3'b011,
		H_RECOV = 3'b100
	} sesc_host_st_e;
endpackage : sesc_pkg

// ### sesc_if.sv
// Purpose : Two-wire link between the bus master and the EEPROM slave
// Assumes : Both lines are open drain with a pull-up
// Notes   : Line levels are resolved here from the output enables

`timescale 1ns/10ps

// ****************************************************************
// Interface
// ****************************************************************
interface sesc_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND resolution with pull-up
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface : sesc_if

// ### sesc_sync.sv
// Purpose : Two-flop synchroniser and start, stop and clock edge detection
// Assumes : Lines idle high
// Notes   : Edges are seen one to two system clocks after the pin moves

`timescale 1ns/10ps

module sesc_sync
	import sesc_pkg::*;
(
	input  wire logic i_clk_sys,   // System clock
	input  wire logic i_reset_n,   // Async reset, active low
	input  wire logic i_scl,       // Raw clock line
	input  wire logic i_sda,       // Raw data line
	output logic      o_scl,       // Synced clock level
	output logic      o_sda,       // Synced data level
	output logic      o_scl_rise,  // Clock rising pulse
	output logic      o_scl_fall,  // Clock falling pulse
	output logic      o_start,     // Start condition pulse
	output logic      o_stop       // Stop condition pulse
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
	} sesc_sync_s;

	sesc_sync_s r;
	sesc_sync_s next_r;

	// Shift chain, bit 1 clock, bit 0 data
	always_comb
	begin
		next_r    = r;
		next_r.s1 = {i_scl, i_sda};
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
	end

	// State register, lines idle high
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
			r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3};
		else
			r <= next_r;
	end

	// Edge and condition decode from stages two and three
	assign o_scl      = r.s2[1];
	assign o_sda      = r.s2[0];
	assign o_scl_rise = r.s2[1] & ~r.s3[1];
	assign o_scl_fall = ~r.s2[1] & r.s3[1];
	assign o_start    = r.s2[1] & r.s3[1] & ~r.s2[0] & r.s3[0];
	assign o_stop     = r.s2[1] & r.s3[1] & r.s2[0] & ~r.s3[0];
endmodule : sesc_sync

// ### sesc_device.sv
// Purpose : Two-wire EEPROM slave, 8 KiB array plus address and protect config
// Assumes : Bus clock from the master, sampled by the system clock
// Notes   : Nonvolatile bits take factory values at reset (power-up)

`timescale 1ns/10ps

module sesc_device
	import sesc_pkg::*;
#(
	parameter int WR_CNT  = WR_CYCLES,  // Data write cycle length
	parameter int CFG_CNT = CFG_CYCLES  // Config write cycle length
)
(
	input  wire logic  i_clk_sys,       // System clock
	input  wire logic  i_reset_n,       // Async reset, active low
	sesc_if.device     bus,             // Two-wire link
	output logic       o_standby,       // Low-power standby
	output logic       o_busy,          // Internal write cycle running
	output logic       o_write_protect, // Current protect bit
	output logic [2:0] o_addr_select    // Current address-select bits
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		sesc_dev_st_e       st;
		logic [3:0]         bitc;
		logic               ack_ph;
		logic               tx;
		logic [7:0]         rxb;
		logic [7:0]         txb;
		logic               sda_low;
		logic [ADDR_W-1:0]  addr;
		logic               is_cfg;
		logic               cfg_sel;
		logic               cfg_done;
		logic               wr_pend;
		logic               cfg_pend;
		logic [7:0]         cfg_new;
		logic [2:0]         addr_select;
		logic               write_protect;
		logic [BUSY_W-1:0]  busy_cnt;
		logic               standby;
	} sesc_dev_s;

	sesc_dev_s          r;
	sesc_dev_s          next_r;
	logic [7:0]         mem [MEM_BYTES];
	logic               mem_we;
	logic [ADDR_W-1:0]  mem_wa;
	logic [7:0]         mem_wd;
	logic               scl_s;
	logic               sda_s;
	logic               rise;
	logic               fall;
	logic               start;
	logic               stop;

	// Line synchroniser and condition detector
	sesc_sync u_sync (
		.i_clk_sys  (i_clk_sys),
		.i_reset_n  (i_reset_n),
		.i_scl      (bus.scl),
		.i_sda      (bus.sda),
		.o_scl      (scl_s),
		.o_sda      (sda_s),
		.o_scl_rise (rise),
		.o_scl_fall (fall),
		.o_start    (start),
		.o_stop     (stop)
	);

	// Readable config byte
	function automatic logic [7:0] cfg_byte(input logic [2:0] as, input logic wp);
		logic [7:0] b;
		b                           = 8'h00;
		b[CFG_AS_MSB:CFG_AS_LSB]    = as;
		b[CFG_WP_BIT]               = wp;
		return b;
	endfunction : cfg_byte

	// ****************************************************************
	// Protocol engine
	// ****************************************************************
	always_comb
	begin
		next_r = r;
		mem_we = 1'b0;
		mem_wa = r.addr;
		mem_wd = r.rxb;
		if (r.st == D_BUSY)
		begin
			// Bus inputs disabled until the cycle completes
			next_r.sda_low = 1'b0;
			if (r.busy_cnt == '0)
			begin
				next_r.st      = D_IDLE;
				next_r.standby = 1'b1;
			end
			else
				next_r.busy_cnt = r.busy_cnt - 1'b1;
		end
		else if (start)
		begin
			next_r.st      = D_DEV;
			next_r.bitc    = 4'h0;
			next_r.ack_ph  = 1'b0;
			next_r.sda_low = 1'b0;
			next_r.standby = 1'b0;
		end
		else if (stop)
		begin
			next_r.sda_low = 1'b0;
			next_r.ack_ph  = 1'b0;
			if (r.cfg_pend)
			begin
				// Select bits only change while unprotected
				next_r.write_protect = r.cfg_new[CFG_WP_BIT];
				if (!r.write_protect)
					next_r.addr_select = r.cfg_new[CFG_AS_MSB:CFG_AS_LSB];
				next_r.busy_cnt = BUSY_W'(CFG_CNT - 1);
				next_r.st       = D_BUSY;
			end
			else if (r.wr_pend)
			begin
				next_r.busy_cnt = BUSY_W'(WR_CNT - 1);
				next_r.st       = D_BUSY;
			end
			else
			begin
				next_r.st      = D_IDLE;
				next_r.standby = 1'b1;
			end
			next_r.cfg_pend = 1'b0;
			next_r.wr_pend  = 1'b0;
		end
		else if (r.st != D_IDLE && r.st != D_IGN)
		begin
			// Count data clocks, sample receive bits on rise
			if (rise && !r.ack_ph && r.bitc < 4'h8)
			begin
				next_r.rxb  = {r.rxb[6:0], sda_s};
				next_r.bitc = r.bitc + 4'h1;
			end
			// Master acknowledge after a transmitted byte
			if (rise && r.ack_ph && r.st == D_RD && r.tx)
			begin
				if (sda_s || r.is_cfg)
					next_r.st = D_IGN;
				else
					next_r.addr = r.addr + 1'b1;
			end
			// Transmit bits change after fall
			if (fall && r.st == D_RD && !r.ack_ph && r.bitc != 4'h0 && r.bitc < 4'h8)
				next_r.sda_low = ~r.txb[3'(4'd7 - r.bitc)];
			if (fall && r.st == D_RD && !r.ack_ph && r.bitc == 4'h8)
			begin
				next_r.sda_low = 1'b0;
				next_r.ack_ph  = 1'b1;
			end
			// End of ninth clock: release, load next read byte
			if (fall && r.ack_ph)
			begin
				next_r.ack_ph  = 1'b0;
				next_r.bitc    = 4'h0;
				next_r.sda_low = 1'b0;
				if (r.st == D_RD)
				begin
					next_r.txb     = r.is_cfg ? cfg_byte(r.addr_select, r.write_protect)
						: mem[r.addr];
					next_r.sda_low = r.is_cfg ? ~r.addr_select[2] : ~mem[r.addr][7];
					next_r.tx      = 1'b1;
				end
			end
			// Eighth clock ended: decode byte and acknowledge
			if (fall && !r.ack_ph && r.bitc == 4'h8 && r.st != D_RD)
			begin
				next_r.ack_ph  = 1'b1;
				next_r.sda_low = 1'b1;
				case (r.st)
					D_DEV:
					begin
						if ((r.rxb[7:4] == TYPE_MEM || r.rxb[7:4] == TYPE_CFG)
							&& r.rxb[3:1] == r.addr_select)
						begin
							next_r.is_cfg = (r.rxb[7:4] == TYPE_CFG);
							next_r.tx     = 1'b0;
							next_r.st     = r.rxb[0] ? D_RD : D_AHI;
						end
						else
						begin
							next_r.sda_low = 1'b0;
							next_r.st      = D_IGN;
						end
					end
					D_AHI:
					begin
						if (r.is_cfg)
						begin
							next_r.cfg_sel = (r.rxb[2:1] == CFG_SEL_VAL);
							next_r.sda_low = (r.rxb[2:1] == CFG_SEL_VAL);
							next_r.st      = (r.rxb[2:1] == CFG_SEL_VAL) ? D_ALO : D_IGN;
						end
						else
						begin
							next_r.cfg_sel = 1'b0;
							next_r.addr    = {r.rxb[ADDR_W-9:0], r.addr[7:0]};
							next_r.st      = D_ALO;
						end
					end
					D_ALO:
					begin
						if (!r.cfg_sel)
							next_r.addr = {r.addr[ADDR_W-1:8], r.rxb};
						next_r.cfg_done = 1'b0;
						next_r.st       = D_WR;
					end
					D_WR:
					begin
						if (r.cfg_sel)
						begin
							// Exactly one config byte accepted
							if (!r.cfg_done)
							begin
								next_r.cfg_new  = r.rxb;
								next_r.cfg_pend = 1'b1;
								next_r.cfg_done = 1'b1;
							end
							else
							begin
								next_r.sda_low = 1'b0;
								next_r.st      = D_IGN;
							end
						end
						else if (r.write_protect)
						begin
							next_r.sda_low = 1'b0;
							next_r.st      = D_IGN;
						end
						else
						begin
							// Store and wrap within the page
							mem_we              = 1'b1;
							next_r.wr_pend      = 1'b1;
							next_r.addr[PAGE_OFS_W-1:0] = r.addr[PAGE_OFS_W-1:0] + 1'b1;
						end
					end
					default:
						next_r.sda_low = 1'b0;
				endcase
			end
		end
	end

	// State register, nonvolatile bits at factory values
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			r               <= '0;
			r.st            <= D_IDLE;
			r.addr_select   <= AS_RESET;
			r.write_protect <= WP_RESET;
			r.standby       <= 1'b1;
		end
		else
			r <= next_r;
	end

	// Array storage, written as each byte is acknowledged
	always_ff @(posedge i_clk_sys)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign bus.dev_sda_o   = 1'b0;
	assign bus.dev_sda_oe  = r.sda_low;
	assign o_standby       = r.standby;
	assign o_busy          = (r.st == D_BUSY);
	assign o_write_protect = r.write_protect;
	assign o_addr_select   = r.addr_select;
endmodule : sesc_device

// ### sesc_host.sv
// Purpose : Two-wire bus master issuing start, stop, byte and recovery steps
// Assumes : Link clock is a divided system clock, no clock stretching
// Notes   : One command at a time; each quarter bit lasts QTR_CYCLES clocks

`timescale 1ns/10ps

module sesc_host
	import sesc_pkg::*;
(
	input  wire logic      i_clk_sys,   // System clock
	input  wire logic      i_reset_n,   // Async reset, active low
	sesc_if.host           bus,         // Two-wire link
	input  wire logic      i_cmd_valid, // Command request
	input  wire sesc_cmd_e i_cmd,       // Command code
	input  wire logic [7:0] i_wdata,    // Byte to write
	output logic           o_cmd_ready, // Ready for a command
	output logic           o_done,      // Command finished pulse
	output logic [7:0]     o_rdata,     // Byte read
	output logic           o_ack        // Ack seen in ninth bit of last byte
);
	typedef struct packed {
		sesc_host_st_e st;
		sesc_cmd_e     cmd;
		logic [1:0]    q;
		logic [7:0]    div;
		logic [3:0]    bitc;
		logic [7:0]    sh;
		logic [7:0]    rdata;
		logic          ack;
		logic          done;
		logic          hit;
		logic          scl_low;
		logic          sda_low;
	} sesc_host_s;

	sesc_host_s r;
	sesc_host_s next_r;
	logic       sda_s;
	logic       tick;

	// Data line synchroniser
	sesc_sync u_sync (
		.i_clk_sys  (i_clk_sys),
		.i_reset_n  (i_reset_n),
		.i_scl      (bus.scl),
		.i_sda      (bus.sda),
		.o_scl      (),
		.o_sda      (sda_s),
		.o_scl_rise (),
		.o_scl_fall (),
		.o_start    (),
		.o_stop     ()
	);

	assign tick = (r.div == 8'(QTR_CYCLES - 1));

	// ****************************************************************
	// Quarter-bit sequencer
	// ****************************************************************
	always_comb
	begin
		next_r      = r;
		next_r.done = 1'b0;
		next_r.div  = tick ? 8'h00 : r.div + 8'h01;
		if (r.st == H_IDLE)
		begin
			if (i_cmd_valid)
			begin
				next_r.cmd  = i_cmd;
				next_r.q    = 2'h0;
				next_r.div  = 8'h00;
				next_r.bitc = 4'h0;
				next_r.hit  = 1'b0;
				next_r.sh   = (i_cmd == CMD_WRITE) ? i_wdata : 8'hFF;
				case (i_cmd)
					CMD_START:   next_r.st = H_START;
					CMD_STOP:    next_r.st = H_STOP;
					CMD_RECOVER: next_r.st = H_RECOV;
					default:     next_r.st = H_BYTE;
				endcase
			end
		end
		else if (tick)
		begin
			next_r.q = r.q + 2'h1;
			case (r.st)
				H_START:
				begin
					// Data falls while clock high
					case (r.q)
						2'h0: next_r.sda_low = 1'b0;
						2'h1: next_r.scl_low = 1'b0;
						2'h2: next_r.sda_low = 1'b1;
						default:
						begin
							next_r.scl_low = 1'b1;
							next_r.st      = H_IDLE;
							next_r.done    = 1'b1;
						end
					endcase
				end
				H_STOP:
				begin
					case (r.q)
						2'h0: next_r.sda_low = 1'b1;
						2'h1: next_r.scl_low = 1'b0;
						2'h2: next_r.sda_low = 1'b0;
						default:
						begin
							next_r.st   = H_IDLE;
							next_r.done = 1'b1;
						end
					endcase
				end
				H_BYTE, H_RECOV:
				begin
					case (r.q)
						2'h0:
						begin
							// Data moves only with clock low
							if (r.st == H_RECOV)
								next_r.sda_low = 1'b0;
							else if (r.bitc < 4'h8)
								next_r.sda_low = (r.cmd == CMD_WRITE) & ~r.sh[7];
							else
								next_r.sda_low = (r.cmd == CMD_READ_ACK);
						end
						2'h1: next_r.scl_low = 1'b0;
						2'h2:
						begin
							if (r.st == H_RECOV)
								next_r.hit = sda_s;
							else if (r.bitc < 4'h8)
								next_r.sh = {r.sh[6:0], sda_s};
							else
								next_r.ack = ~sda_s;
						end
						default:
						begin
							next_r.scl_low = 1'b1;
							if (r.st == H_RECOV && (r.hit || r.bitc == 4'h8))
								next_r.st = H_START;
							else if (r.st == H_BYTE && r.bitc == 4'h8)
							begin
								next_r.sda_low = 1'b0;
								next_r.rdata   = r.sh;
								next_r.st      = H_IDLE;
								next_r.done    = 1'b1;
							end
							else
								next_r.bitc = r.bitc + 4'h1;
						end
					endcase
				end
				default: next_r.st = H_IDLE;
			endcase
		end
	end

	// State register, both lines released
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			r     <= '0;
			r.st  <= H_IDLE;
			r.cmd <= CMD_START;
		end
		else
			r <= next_r;
	end

	assign bus.host_scl_o  = 1'b0;
	assign bus.host_scl_oe = r.scl_low;
	assign bus.host_sda_o  = 1'b0;
	assign bus.host_sda_oe = r.sda_low;
	assign o_cmd_ready     = (r.st == H_IDLE);
	assign o_done          = r.done;
	assign o_rdata         = r.rdata;
	assign o_ack           = r.ack;
endmodule : sesc_host

// ### sesc_chk.sv
// Purpose : Link checks between the bus master and the slave
// Assumes : Both lines sampled by the system clock
// Notes   : Sees only the interface signals
`timescale 1ns/10ps
// ****************************************************************
// Checker
// ****************************************************************
module sesc_chk (
	input  wire logic i_clk_sys,  // System clock
	input  wire logic i_reset_n,  // Async reset, active low
	input  wire logic host_scl_o, // Master clock drive value
	input  wire logic host_sda_o, // Master data drive value
	input  wire logic dev_sda_o,  // Slave data drive value
	input  wire logic dev_sda_oe, // Slave pulls data low
	input  wire logic scl,        // Clock level
	input  wire logic sda         // Data level
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_cnt;
	logic       rd;
	logic       first;
	logic       start_c;
	logic       stop_c;
	// Start and stop seen on the wire
	assign start_c = scl && scl_q && sda_q && !sda;
	assign stop_c  = scl && scl_q && !sda_q && sda;
	// Bit slot and direction since the last start
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			bit_cnt <= 4'h0;
			rd      <= 1'b0;
			first   <= 1'b0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			if (start_c)
			begin
				bit_cnt <= 4'h0;
				rd      <= 1'b0;
				first   <= 1'b1;
			end
			else if (scl && !scl_q)
			begin
				bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
				if (first && bit_cnt == 4'h7)
					rd <= sda;
				if (bit_cnt == 4'h9)
					first <= 1'b0;
			end
		end
	end
	sequence s_quiet;
		!dev_sda_oe [*8];
	endsequence
	sequence s_scl_high;
		scl [*8];
	endsequence
	dev_drain_a: assert property (dev_sda_o == 1'b0)
		else $error("slave drives data high");
	host_drain_a: assert property (!host_scl_o && !host_sda_o)
		else $error("master drives a line high");
	oe_change_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("slave data moved with clock high");
	stop_quiet_a: assert property (stop_c |-> s_quiet)
		else $error("slave drives after stop");
	start_quiet_a: assert property (start_c |=> s_quiet)
		else $error("slave drives after start");
	ack_slot_a: assert property (scl && scl_q && !rd && dev_sda_oe |-> bit_cnt == 4'h9)
		else $error("slave pulls data outside ack slot");
	read_ack_a: assert property (scl && scl_q && rd && !first && bit_cnt == 4'h9 |-> !dev_sda_oe)
		else $error("slave holds data in master ack slot");
	scl_high_a: assert property ($rose(scl) |-> s_scl_high)
		else $error("clock high phase too short");
endmodule : sesc_chk

// ### serial_eeprom_slave_config_tb.sv
// Purpose : Self-checking bench for the master and slave pair
// Assumes : Write cycles shortened to 400 clocks
// Notes   : All traffic goes through the master command port
`timescale 1ns/10ps
// ****************************************************************
// Testbench
// ****************************************************************
module serial_eeprom_slave_config_tb
	import sesc_pkg::*;
;
	logic       clk;
	logic       rst_n;
	logic       cmd_valid;
	sesc_cmd_e  cmd;
	logic [7:0] wdata;
	logic       done;
	logic       ready;
	logic [7:0] rdata;
	logic       ack;
	logic       standby;
	logic       busy;
	logic       wp;
	logic [2:0] asel;
	int         n_errors;
	int         compares;
	int         cycles;
	sesc_if link ();
	sesc_device #(.WR_CNT(400), .CFG_CNT(400)) sesc_device_i (.i_clk_sys(clk),
		.i_reset_n(rst_n), .bus(link), .o_standby(standby), .o_busy(busy),
		.o_write_protect(wp), .o_addr_select(asel));
	sesc_host sesc_host_i (.i_clk_sys(clk), .i_reset_n(rst_n), .bus(link),
		.i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_wdata(wdata), .o_cmd_ready(ready),
		.o_done(done), .o_rdata(rdata), .o_ack(ack));
	sesc_chk sesc_chk_i (.i_clk_sys(clk), .i_reset_n(rst_n),
		.host_scl_o(link.host_scl_o), .host_sda_o(link.host_sda_o),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
		.scl(link.scl), .sda(link.sda));
	// Clock
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	// One master command, called at a falling edge
	task automatic issue(input sesc_cmd_e c, input logic [7:0] d);
		int n;
		n         = 0;
		chk("ready", 8'h01, {7'h0, ready});
		cmd_valid = 1'b1;
		cmd       = c;
		wdata     = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		chk("done", 8'h01, {7'h0, done});
	endtask : issue
	task automatic wb(input logic [7:0] d, input logic e);
		issue(CMD_WRITE, d);
		chk("ack", {7'h0, e}, {7'h0, ack});
	endtask : wb
	task automatic rb(input logic last, input logic [7:0] e);
		if (last)
			issue(CMD_READ_NACK, 8'h00);
		else
			issue(CMD_READ_ACK, 8'h00);
		chk("rdata", e, rdata);
	endtask : rb
	task automatic head(input logic [7:0] dev, input logic [7:0] hi, input logic [7:0] lo);
		issue(CMD_START, 8'h00);
		wb(dev, 1'b1);
		wb(hi, 1'b1);
		wb(lo, 1'b1);
	endtask : head
	task automatic settle();
		int n;
		n = 0;
		while (!(busy === 1'b0 && standby === 1'b1) && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		chk("standby", 8'h01, {7'h0, standby});
	endtask : settle
	task automatic rd_at(input logic [7:0] dev, input logic [7:0] hi, input logic [7:0] lo,
		input logic [7:0] e);
		head(dev, hi, lo);
		issue(CMD_START, 8'h00);
		wb(dev | 8'h01, 1'b1);
		rb(1'b1, e);
		issue(CMD_STOP, 8'h00);
		settle();
	endtask : rd_at
	// Cut a hung run short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_errors++;
			report_and_stop();
		end
	end
	// Main sequence
	initial
	begin
		clk       = 1'b0;
		rst_n     = 1'b0;
		cmd_valid = 1'b0;
		cmd       = CMD_START;
		wdata     = 8'h00;
		n_errors  = 0;
		compares  = 0;
		cycles    = 0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		chk("standby", 8'h01, {7'h0, standby});
		chk("select", 8'h00, {5'h0, asel});
		chk("protect", 8'h00, {7'h0, wp});
		$display("test power-up done");
		head(8'hA0, 8'hE1, 8'hFE);
		wb(8'h11, 1'b1);
		wb(8'h22, 1'b1);
		wb(8'h33, 1'b1);
		issue(CMD_STOP, 8'h00);
		chk("busy", 8'h01, {7'h0, busy});
		issue(CMD_START, 8'h00);
		wb(8'hA0, 1'b0);
		issue(CMD_STOP, 8'h00);
		settle();
		head(8'hA0, 8'h01, 8'hFE);
		issue(CMD_START, 8'h00);
		wb(8'hA1, 1'b1);
		rb(1'b0, 8'h11);
		rb(1'b1, 8'h22);
		issue(CMD_STOP, 8'h00);
		settle();
		rd_at(8'hA0, 8'h01, 8'hE0, 8'h33);
		issue(CMD_START, 8'h00);
		wb(8'hA2, 1'b0);
		wb(8'h00, 1'b0);
		issue(CMD_STOP, 8'h00);
		$display("test data done");
		head(8'hB0, 8'h06, 8'h00);
		wb(8'h22, 1'b1);
		issue(CMD_STOP, 8'h00);
		issue(CMD_START, 8'h00);
		wb(8'hB0, 1'b0);
		issue(CMD_STOP, 8'h00);
		settle();
		chk("select", 8'h01, {5'h0, asel});
		chk("protect", 8'h01, {7'h0, wp});
		issue(CMD_START, 8'h00);
		wb(8'hA0, 1'b0);
		issue(CMD_STOP, 8'h00);
		head(8'hA2, 8'h01, 8'hFF);
		wb(8'h99, 1'b0);
		issue(CMD_STOP, 8'h00);
		settle();
		rd_at(8'hB2, 8'h06, 8'h00, 8'h22);
		head(8'hB2, 8'h07, 8'h5A);
		wb(8'h40, 1'b1);
		wb(8'h00, 1'b0);
		issue(CMD_STOP, 8'h00);
		settle();
		chk("select", 8'h01, {5'h0, asel});
		chk("protect", 8'h00, {7'h0, wp});
		issue(CMD_START, 8'h00);
		wb(8'hB2, 1'b1);
		wb(8'h02, 1'b0);
		issue(CMD_STOP, 8'h00);
		$display("test config done");
		issue(CMD_START, 8'h00);
		wb(8'hA2, 1'b1);
		issue(CMD_RECOVER, 8'h00);
		wb(8'hA3, 1'b1);
		rb(1'b1, 8'h22);
		issue(CMD_STOP, 8'h00);
		settle();
		$display("test recovery done");
		report_and_stop();
	end
endmodule : serial_eeprom_slave_config_tb
